// File: design/alu_subset.sv
/*
 * Execution datapath for five 8-bit operations: subtract with borrow, nibble
 * swap, xor with literal, xor with file register, load of a port direction.
 * Assumes the decoder holds op/operands stable for the two cycles of an
 * operation and starts one only when ready_o is high.
 */
module alu_subset (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       start_i,
   input  wire logic [2:0] op_i,
   input  wire logic [6:0] file_addr_i,
   input  wire logic       dest_i,
   input  wire logic [7:0] literal_i,
   input  wire logic       acc_load_i,
   input  wire logic [7:0] acc_data_i,
   output logic            ready_o,
   output logic            done_o,
   output logic      [7:0] acc_o,
   output logic            carry_o,
   output logic            nibble_borrow_flag_o,
   output logic            zero_o,
   output logic      [7:0] port_a_direction_o,
   output logic      [7:0] port_b_direction_o,
   output logic      [7:0] port_c_direction_o,
   output logic      [7:0] file_rdata_o
);

   // ==========================================================
   // Sequencer
   // ==========================================================
   typedef enum logic [1:0] {
      IDLE_S  = 2'b01,
      EXEC_S  = 2'b10
   } state_type;

   state_type  state_reg;
   logic [2:0] op_reg;
   logic [6:0] addr_reg;
   logic       dest_reg;
   logic [7:0] lit_reg;
   logic [7:0] file_q;
   logic [7:0] result;
   logic [8:0] diff9;
   logic [4:0] diff5;
   logic       exec;
   logic       file_we;
   logic [6:0] read_addr;

   assign ready_o = (state_reg == IDLE_S);
   assign exec    = (state_reg == EXEC_S);

   // First cycle fetches the file byte, second computes and writes back
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= IDLE_S;
      end else begin
         case (state_reg)
            IDLE_S:  state_reg <= (start_i && op_i != alu_subset_pkg::OP_NONE) ? EXEC_S : IDLE_S;
            EXEC_S:  state_reg <= IDLE_S;
            default: state_reg <= IDLE_S;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_reg   <= alu_subset_pkg::OP_NONE;
         addr_reg <= 7'h00;
         dest_reg <= alu_subset_pkg::DEST_ACC;
         lit_reg  <= 8'h00;
      end else if (ready_o && start_i) begin
         op_reg   <= op_i;
         addr_reg <= file_addr_i;
         dest_reg <= dest_i;
         lit_reg  <= literal_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_o <= 1'b0;
      end else begin
         done_o <= exec;
      end
   end

   // ==========================================================
   // Result calculation
   // ==========================================================
   // Borrow is the inverse of carry, so subtract one when carry is clear
   // subtract with borrow
   assign diff9 = {1'b0, file_q} + {1'b0, ~acc_o} + {8'h00, carry_o};
   assign diff5 = {1'b0, file_q[3:0]} + {1'b0, ~acc_o[3:0]} + {4'h0, carry_o};

   always_comb begin
      case (op_reg)
         alu_subset_pkg::OP_SUB_BOR:  result = diff9[7:0];
         alu_subset_pkg::OP_SWAP:     result = {file_q[3:0], file_q[7:4]};
         alu_subset_pkg::OP_XOR_LIT:  result = acc_o ^ lit_reg;
         alu_subset_pkg::OP_XOR_FILE: result = acc_o ^ file_q;
         default:                     result = acc_o;
      endcase
   end

   // ==========================================================
   // File registers
   // ==========================================================
   // Idle reads follow the address pins so the operand stands in the execute
   // cycle; reading only the captured address would hand over a stale byte
   assign read_addr = ready_o ? file_addr_i : addr_reg;

   assign file_we = exec && dest_reg == alu_subset_pkg::DEST_FILE
                    && (op_reg == alu_subset_pkg::OP_SUB_BOR
                        || op_reg == alu_subset_pkg::OP_SWAP
                        || op_reg == alu_subset_pkg::OP_XOR_FILE);

   file_regs u_file (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (file_we),
      .waddr_i (addr_reg),
      .wdata_i (result),
      .raddr_i (read_addr),
      .rdata_o (file_q)
   );

   assign file_rdata_o = file_q;

   // ==========================================================
   // Accumulator
   // ==========================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_o <= alu_subset_pkg::ACC_RESET;
      end else if (exec) begin
         if (op_reg == alu_subset_pkg::OP_XOR_LIT
             || (dest_reg == alu_subset_pkg::DEST_ACC
                 && (op_reg == alu_subset_pkg::OP_SUB_BOR
                     || op_reg == alu_subset_pkg::OP_SWAP
                     || op_reg == alu_subset_pkg::OP_XOR_FILE))) begin
            acc_o <= result;
         end
      end else if (acc_load_i && ready_o) begin
         acc_o <= acc_data_i;
      end
   end

   // ==========================================================
   // Status flags
   // ==========================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         carry_o              <= alu_subset_pkg::FLAG_RESET;
         nibble_borrow_flag_o <= alu_subset_pkg::FLAG_RESET;
      end else if (exec && op_reg == alu_subset_pkg::OP_SUB_BOR) begin
         carry_o              <= diff9[8];
         nibble_borrow_flag_o <= diff5[4];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         zero_o <= alu_subset_pkg::FLAG_RESET;
      end else if (exec && (op_reg == alu_subset_pkg::OP_SUB_BOR
                            || op_reg == alu_subset_pkg::OP_XOR_LIT
                            || op_reg == alu_subset_pkg::OP_XOR_FILE)) begin
         zero_o <= (result == 8'h00);
      end
   end

   // ==========================================================
   // Port direction registers
   // ==========================================================
   // Out-of-range selects are ignored; reset leaves all pins as inputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_a_direction_o <= alu_subset_pkg::DIR_RESET;
         port_b_direction_o <= alu_subset_pkg::DIR_RESET;
         port_c_direction_o <= alu_subset_pkg::DIR_RESET;
      end else if (exec && op_reg == alu_subset_pkg::OP_LOAD_DIR) begin
         if (lit_reg == alu_subset_pkg::DIR_SEL_A) port_a_direction_o <= acc_o;
         if (lit_reg == alu_subset_pkg::DIR_SEL_B) port_b_direction_o <= acc_o;
         if (lit_reg == alu_subset_pkg::DIR_SEL_C) port_c_direction_o <= acc_o;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   sub_result_a: assert property (@(posedge clk_i) disable iff (rst_i)
      exec && op_reg == alu_subset_pkg::OP_SUB_BOR && dest_reg == 1'b0 |=>
      acc_o == 8'($past(file_q) - $past(acc_o) - {7'h00, ~$past(carry_o)}))
      else $error("subtract result wrong");
   sub_dest_a: assert property (@(posedge clk_i) disable iff (rst_i)
      exec && op_reg == alu_subset_pkg::OP_SUB_BOR && dest_reg |=> $stable(acc_o))
      else $error("subtract to file touched accumulator");
   swap_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
      exec && op_reg == alu_subset_pkg::OP_SWAP |=>
      $stable(carry_o) && $stable(zero_o) && $stable(nibble_borrow_flag_o))
      else $error("swap changed flags");
   swap_dest_a: assert property (@(posedge clk_i) disable iff (rst_i)
      exec && op_reg == alu_subset_pkg::OP_SWAP && !dest_reg |=>
      acc_o == {$past(file_q[3:0]), $past(file_q[7:4])})
      else $error("swap result wrong");
   xor_lit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      exec && op_reg == alu_subset_pkg::OP_XOR_LIT |=>
      acc_o == ($past(acc_o) ^ $past(lit_reg)) && $stable(carry_o))
      else $error("literal xor wrong");
   dir_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
      exec && op_reg == alu_subset_pkg::OP_LOAD_DIR && lit_reg == alu_subset_pkg::DIR_SEL_B |=>
      port_b_direction_o == $past(acc_o) && $stable(zero_o))
      else $error("direction load wrong");
   xor_file_a: assert property (@(posedge clk_i) disable iff (rst_i)
      exec && op_reg == alu_subset_pkg::OP_XOR_FILE && !dest_reg |=>
      acc_o == ($past(acc_o) ^ $past(file_q)) && $stable(nibble_borrow_flag_o))
      else $error("file xor wrong");
   zero_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      exec && op_reg == alu_subset_pkg::OP_XOR_LIT |=> zero_o == (acc_o == 8'h00))
      else $error("zero flag wrong");
   op_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ready_o && start_i && op_i != alu_subset_pkg::OP_NONE |=> ##1 done_o)
      else $error("operation did not finish");

   sub_file_c: cover property (@(posedge clk_i) disable iff (rst_i)
      exec && op_reg == alu_subset_pkg::OP_SUB_BOR && dest_reg);
   swap_c: cover property (@(posedge clk_i) disable iff (rst_i)
      exec && op_reg == alu_subset_pkg::OP_SWAP);
   dir_c: cover property (@(posedge clk_i) disable iff (rst_i)
      exec && op_reg == alu_subset_pkg::OP_LOAD_DIR);

endmodule

// File: design/alu_subset_pkg.sv
/*
 * Constants for the five-operation execution datapath: operation codes,
 * operand ranges and reset values.
 * Assumes a single 50 MHz core clock and a synchronous active-high reset.
 */
package alu_subset_pkg;

   // ==========================================================
   // Operation select codes
   // ==========================================================
   localparam logic [2:0] OP_NONE     = 3'h0;
   localparam logic [2:0] OP_SUB_BOR  = 3'h1;
   localparam logic [2:0] OP_SWAP     = 3'h2;
   localparam logic [2:0] OP_XOR_LIT  = 3'h3;
   localparam logic [2:0] OP_XOR_FILE = 3'h4;
   localparam logic [2:0] OP_LOAD_DIR = 3'h5;

   // ==========================================================
   // Operand ranges and reset values
   // ==========================================================
   localparam int         DATA_W      = 8;
   localparam int         ADDR_W      = 7;
   localparam int         FILE_DEPTH  = 128;
   localparam logic [7:0] DIR_SEL_A   = 8'h05;
   localparam logic [7:0] DIR_SEL_B   = 8'h06;
   localparam logic [7:0] DIR_SEL_C   = 8'h07;
   localparam logic [7:0] ACC_RESET   = 8'h00;
   localparam logic [7:0] FILE_RESET  = 8'h00;
   localparam logic [7:0] DIR_RESET   = 8'hff;
   localparam logic       FLAG_RESET  = 1'h0;
   localparam logic       DEST_ACC    = 1'h0;
   localparam logic       DEST_FILE   = 1'h1;

endpackage

// File: design/file_regs.sv
/*
 * File register memory: 128 bytes, one write port, one registered read port,
 * cleared by the core reset.
 * Assumes address and write strobe come from logic on the same clock.
 */
module file_regs (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       we_i,
   input  wire logic [6:0] waddr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic [6:0] raddr_i,
   output logic      [7:0] rdata_o
);

   logic [7:0] mem_reg [0:alu_subset_pkg::FILE_DEPTH-1];

   // ==========================================================
   // Storage
   // ==========================================================
   // Cleared on reset: subtract, swap and file xor read a file byte, so an unknown byte
   // would spread into the accumulator; costs flops instead of a plain RAM
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < alu_subset_pkg::FILE_DEPTH; k++) begin
            mem_reg[k] <= alu_subset_pkg::FILE_RESET;
         end
      end else if (we_i) begin
         mem_reg[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      rdata_o <= mem_reg[raddr_i];
   end

endmodule

// File: tb/tb_mcu_alu_subset_ops.sv
/*
 * Self-checking bench for the five-operation datapath: an integer model of
 * accumulator, flags, direction registers and file memory is compared with
 * the design after every operation, with directed and random traffic.
 * Assumes alu_subset_pkg is compiled first and the clock is 50 MHz.
 */
module tb_mcu_alu_subset_ops;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Design ports and model state
   // ==========================================================
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       start_i = 1'b0;
   logic       dest_i = 1'b0;
   logic       acc_load_i = 1'b0;
   logic [2:0] op_i = 3'h0;
   logic [6:0] file_addr_i = 7'h00;
   logic [7:0] literal_i = 8'h00;
   logic [7:0] acc_data_i = 8'h00;
   logic       ready_o, done_o, carry_o, nibble_borrow_flag_o, zero_o;
   logic [7:0] acc_o, file_rdata_o;
   logic [7:0] dir_o [3];
   logic [7:0] m_acc, m_file [128];
   logic [7:0] m_dir [3];
   logic       m_c, m_nbf, m_z;
   logic [31:0] rng = 32'h4037;
   int         mismatches = 0;
   int         checks_done = 0;

   always #10 clk_i = ~clk_i;

   alu_subset alu_subset_i (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i),
      .file_addr_i(file_addr_i), .dest_i(dest_i), .literal_i(literal_i),
      .acc_load_i(acc_load_i), .acc_data_i(acc_data_i), .ready_o(ready_o),
      .done_o(done_o), .acc_o(acc_o), .carry_o(carry_o),
      .nibble_borrow_flag_o(nibble_borrow_flag_o), .zero_o(zero_o),
      .port_a_direction_o(dir_o[0]), .port_b_direction_o(dir_o[1]),
      .port_c_direction_o(dir_o[2]), .file_rdata_o(file_rdata_o));

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [31:0] next_rand();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_all();
      chk("acc", m_acc, acc_o);
      chk("carry", {7'h00, m_c}, {7'h00, carry_o});
      chk("nibble_borrow", {7'h00, m_nbf}, {7'h00, nibble_borrow_flag_o});
      chk("zero", {7'h00, m_z}, {7'h00, zero_o});
      for (int k = 0; k < 3; k++) chk("direction", m_dir[k], dir_o[k]);
   endtask

   task automatic load_acc(input logic [7:0] v);
      acc_load_i = 1'b1;
      acc_data_i = v;
      @(negedge clk_i);
      acc_load_i = 1'b0;
      m_acc = v;
   endtask

   // One accepted operation; poke raises a second start while busy
   task automatic run_op(input logic [2:0] op, input logic [6:0] a, input logic d,
                         input logic [7:0] lit, input logic poke);
      int n;
      logic [7:0] f, res;
      logic [8:0] sum;
      f = m_file[a];
      op_i = op;
      file_addr_i = a;
      dest_i = d;
      literal_i = lit;
      start_i = 1'b1;
      @(negedge clk_i);
      start_i = poke;
      op_i = alu_subset_pkg::OP_XOR_LIT;
      literal_i = 8'hff;
      n = 0;
      while (done_o !== 1'b1 && n < 8) begin
         @(negedge clk_i);
         start_i = 1'b0;
         n++;
      end
      res = m_acc;
      case (op)
         alu_subset_pkg::OP_SUB_BOR: begin
            sum = {1'b0, f} + {1'b0, ~m_acc} + {8'h00, m_c};
            m_nbf = ({1'b0, f[3:0]} + {1'b0, ~m_acc[3:0]} + {4'h0, m_c}) > 5'h0f;
            m_c = sum[8];
            res = sum[7:0];
            m_z = (res == 8'h00);
         end
         alu_subset_pkg::OP_SWAP: res = {f[3:0], f[7:4]};
         alu_subset_pkg::OP_XOR_FILE: begin
            res = m_acc ^ f;
            m_z = (res == 8'h00);
         end
         alu_subset_pkg::OP_XOR_LIT: begin
            m_acc = m_acc ^ lit;
            m_z = (m_acc == 8'h00);
         end
         default: m_dir[lit - 8'h05] = m_acc;
      endcase
      if (op inside {alu_subset_pkg::OP_SUB_BOR, alu_subset_pkg::OP_SWAP,
                     alu_subset_pkg::OP_XOR_FILE}) begin
         if (d == alu_subset_pkg::DEST_FILE) m_file[a] = res;
         else m_acc = res;
      end
      chk("done", 8'h01, {7'h00, done_o});
      check_all();
      @(negedge clk_i);
      chk("done_pulse", 8'h00, {7'h00, done_o});
      chk("file", m_file[a], file_rdata_o);
   endtask

   // An operation that must change nothing; a bad selector still runs and pulses done
   task automatic refused_op(input logic [2:0] op, input logic [7:0] lit,
                             input logic exp_done);
      op_i = op;
      literal_i = lit;
      start_i = 1'b1;
      @(negedge clk_i);
      start_i = 1'b0;
      for (int j = 0; j < 3; j++) begin
         @(negedge clk_i);
         chk("refused_done", {7'h00, exp_done && j == 0}, {7'h00, done_o});
      end
      check_all();
   endtask

   task automatic test_done();
      $display("Checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      logic [31:0] r;
      logic [2:0] op;
      logic [7:0] lit;
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      m_acc = alu_subset_pkg::ACC_RESET;
      {m_c, m_nbf, m_z} = {3{alu_subset_pkg::FLAG_RESET}};
      for (int k = 0; k < 3; k++) m_dir[k] = alu_subset_pkg::DIR_RESET;
      check_all();
      $display("Test reset values done");
      // File memory clears on reset; walk every address
      for (int a = 0; a < 128; a++) begin
         file_addr_i = a[6:0];
         @(negedge clk_i);
         m_file[a] = alu_subset_pkg::FILE_RESET;
         chk("file_reset", m_file[a], file_rdata_o);
      end
      for (int k = 5; k < 8; k++) begin
         load_acc(8'h30 + k[7:0]);
         run_op(alu_subset_pkg::OP_LOAD_DIR, 7'h00, 1'b0, k[7:0], 1'b0);
      end
      refused_op(alu_subset_pkg::OP_LOAD_DIR, 8'h04, 1'b1);
      refused_op(alu_subset_pkg::OP_LOAD_DIR, 8'h08, 1'b1);
      refused_op(alu_subset_pkg::OP_NONE, 8'h05, 1'b0);
      load_acc(8'h5a);
      run_op(alu_subset_pkg::OP_XOR_LIT, 7'h00, 1'b0, 8'h5a, 1'b0);
      $display("Test directed operations done");
      for (int i = 0; i < 400; i++) begin
         r = next_rand();
         op = 3'h1 + 3'(r[2:0] % 3'h5);
         lit = r[15:8];
         if (op == alu_subset_pkg::OP_LOAD_DIR) lit = 8'h05 + 8'(r[9:8] % 2'h3);
         if (r[16]) load_acc(r[31:24]);
         run_op(op, r[17] ? 7'h7f : {5'h00, r[19:18]}, r[20], lit, r[21]);
      end
      $display("Test random operations done");
      test_done();
   end

   initial begin
      #(20 * 20000);
      mismatches++;
      test_done();
   end
endmodule
